// ==== rtl/mla_top.v ====
// media link loss-of-signal supervision, alignment and serdes
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mla_defines.vh"
module mla_top #(
  parameter [31:0] SET_CYCLES = `MLA_SET_CYCLES,
  parameter [31:0] CLR_CYCLES = `MLA_CLR_CYCLES
) (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // optical receive side
  input wire LEVEL_BELOW_THRESH,
  input wire RX_BIT_CLK,
  input wire RX_BIT,
  // optical transmit side
  output reg TX_BIT,
  output reg TX_BIT_CLK,
  // upper layer receive
  input wire ALIGN_ENABLE_IN,
  input wire TRAIL_FAIL_IN,
  output reg [`MLA_WORD_W-1:0] CODE_GROUP_WORD,
  output reg CODE_GROUP_CLOCK,
  output reg FRAME_START_OUT,
  output reg SERVER_FAIL_OUT,
  output reg TRAIL_FAIL_TO_ADAPTER,
  // upper layer transmit
  input wire [`MLA_WORD_W-1:0] TX_CODE_GROUP,
  output reg TX_CODE_GROUP_CLOCK,
  // management
  output reg MGMT_SIGNAL_LOSS_CAUSE,
  output reg SIGNAL_LOSS_FAULT,
  output reg IRQ,
  // axi4-lite slave
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  localparam W = `MLA_WORD_W;
  localparam [W-1:0] HALF = W / 2;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `MLA_ADDR_CTRL) || (a == `MLA_ADDR_STATUS) ||
        (a == `MLA_ADDR_IRQ_STAT) || (a == `MLA_ADDR_IRQ_MASK) ||
        (a == `MLA_ADDR_RX_WORD) || (a == `MLA_ADDR_TX_WORD);
    end
  endfunction

  // synchronisers: first stage read only by second
  reg [1:0] lvl_s_reg, bclk_s_reg, bit_s_reg, aen_s_reg, tsf_s_reg;
  reg bclk_d_reg;
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lvl_s_reg <= 2'b00;
      bclk_s_reg <= 2'b00;
      bit_s_reg <= 2'b00;
      aen_s_reg <= 2'b00;
      tsf_s_reg <= 2'b00;
      bclk_d_reg <= 1'b0;
    end else begin
      lvl_s_reg <= {lvl_s_reg[0], LEVEL_BELOW_THRESH};
      bclk_s_reg <= {bclk_s_reg[0], RX_BIT_CLK};
      bit_s_reg <= {bit_s_reg[0], RX_BIT};
      aen_s_reg <= {aen_s_reg[0], ALIGN_ENABLE_IN};
      tsf_s_reg <= {tsf_s_reg[0], TRAIL_FAIL_IN};
      bclk_d_reg <= bclk_s_reg[1];
    end
  end
  wire bit_rise = bclk_s_reg[1] & ~bclk_d_reg;
  wire align_en = aen_s_reg[1];

  // registers
  reg [31:0] ctrl_reg;
  reg [3:0] irq_stat_reg, irq_mask_reg;
  reg [W-1:0] tx_word_reg;
  wire [1:0] port_mode = ctrl_reg[`MLA_CTRL_PM_LSB+1:`MLA_CTRL_PM_LSB];
  wire sw_align = ctrl_reg[`MLA_CTRL_AEN_BIT];

  wire signal_loss_anomaly = lvl_s_reg[1];
  wire signal_loss_defect = signal_loss_anomaly;
  localparam [1:0] PS_NMON = 2'h0;
  localparam [1:0] PS_MON = 2'h1;
  reg [1:0] port_state_reg;
  reg [1:0] port_state_next;
  always @* begin
    port_state_next = PS_NMON;
    case (port_state_reg)
      PS_NMON: if (port_mode == `MLA_PM_MON) port_state_next = PS_MON;
      PS_MON: if (port_mode == `MLA_PM_MON) port_state_next = PS_MON;
      default: port_state_next = PS_NMON;
    endcase
  end
  wire monitor_state_flag = (port_state_reg == PS_MON);
  wire signal_loss_cause = monitor_state_flag & signal_loss_defect;
  wire fault;
  mla_fault_timer #(.SET_CYCLES(SET_CYCLES), .CLR_CYCLES(CLR_CYCLES))
    u_timer (.clk(REF_CLK), .rst(RST), .cause(signal_loss_cause),
    .fault_reg(fault));
  reg fault_d_reg;

  // receive shifter: oldest bit at msb
  reg [W-1:0] rx_shift_reg;
  reg [3:0] rx_cnt_reg;
  reg rx_word_ev;
  wire [W-1:0] rx_shift_next = {rx_shift_reg[W-2:0], bit_s_reg[1]};
  wire comma_hit = (rx_shift_next[6:0] == `MLA_COMMA);
  // transmit shifter
  reg [W-1:0] tx_shift_reg;
  reg [3:0] tx_cnt_reg;

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      port_state_reg <= PS_NMON;
      rx_shift_reg <= {W{1'b0}};
      rx_cnt_reg <= 4'h0;
      rx_word_ev <= 1'b0;
      CODE_GROUP_WORD <= {W{1'b0}};
      CODE_GROUP_CLOCK <= 1'b0;
      FRAME_START_OUT <= 1'b0;
      SERVER_FAIL_OUT <= 1'b0;
      TRAIL_FAIL_TO_ADAPTER <= 1'b0;
      MGMT_SIGNAL_LOSS_CAUSE <= 1'b0;
      SIGNAL_LOSS_FAULT <= 1'b0;
      fault_d_reg <= 1'b0;
      tx_shift_reg <= {W{1'b0}};
      tx_cnt_reg <= 4'h0;
      TX_BIT <= 1'b0;
      TX_BIT_CLK <= 1'b0;
      TX_CODE_GROUP_CLOCK <= 1'b0;
    end else begin
      port_state_reg <= port_state_next;
      TRAIL_FAIL_TO_ADAPTER <= signal_loss_defect;
      SERVER_FAIL_OUT <= tsf_s_reg[1];
      MGMT_SIGNAL_LOSS_CAUSE <= signal_loss_cause;
      SIGNAL_LOSS_FAULT <= fault;
      fault_d_reg <= fault;
      rx_word_ev <= 1'b0;
      FRAME_START_OUT <= 1'b0;
      if (bit_rise) begin
        rx_shift_reg <= rx_shift_next;
        if (align_en && comma_hit) begin
          FRAME_START_OUT <= 1'b1;
        end
        if (align_en && comma_hit) begin
          rx_cnt_reg <= 4'd7;
        end else if (rx_cnt_reg == W - 1) begin
          rx_cnt_reg <= 4'h0;
          CODE_GROUP_WORD <= rx_shift_next;
          rx_word_ev <= 1'b1;
        end else begin
          rx_cnt_reg <= rx_cnt_reg + 4'd1;
        end
        CODE_GROUP_CLOCK <= (rx_cnt_reg < HALF[3:0]) ? 1'b0 : 1'b1;
      end
      // transmit bit clock from own clock, 1 bit per 2 cycles
      TX_BIT_CLK <= ~TX_BIT_CLK;
      if (TX_BIT_CLK) begin
        if (tx_cnt_reg == W - 1) begin
          tx_cnt_reg <= 4'h0;
          tx_shift_reg <= sw_align ? tx_word_reg : TX_CODE_GROUP;
          TX_BIT <= tx_shift_reg[W-1];
        end else begin
          tx_cnt_reg <= tx_cnt_reg + 4'd1;
          TX_BIT <= tx_shift_reg[W-1];
          tx_shift_reg <= {tx_shift_reg[W-2:0], 1'b0};
        end
        TX_CODE_GROUP_CLOCK <= (tx_cnt_reg < HALF[3:0]) ? 1'b0 : 1'b1;
      end
    end
  end

  // axi4-lite: write accepted once both address and data held
  reg [7:0] aw_reg;
  reg aw_ok_reg, w_ok_reg;
  reg [31:0] wd_reg;
  wire do_write = aw_ok_reg & w_ok_reg & ~S_AXI_BVALID;
  wire [3:0] ev = {rx_word_ev, FRAME_START_OUT,
    ~fault & fault_d_reg, fault & ~fault_d_reg};
  wire [31:0] status = {25'h0, FRAME_START_OUT, SERVER_FAIL_OUT,
    SIGNAL_LOSS_FAULT, MGMT_SIGNAL_LOSS_CAUSE, monitor_state_flag,
    signal_loss_defect, signal_loss_anomaly};
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      aw_reg <= 8'h00;
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      wd_reg <= 32'h00000000;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= 2'b00;
      ctrl_reg <= `MLA_CTRL_RESET;
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
      tx_word_reg <= {W{1'b0}};
      IRQ <= 1'b0;
    end else begin
      S_AXI_AWREADY <= ~aw_ok_reg & ~S_AXI_AWREADY & S_AXI_AWVALID;
      S_AXI_WREADY <= ~w_ok_reg & ~S_AXI_WREADY & S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_reg <= S_AXI_AWADDR;
        aw_ok_reg <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wd_reg <= S_AXI_WDATA & {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
          {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
        w_ok_reg <= 1'b1;
      end
      // sticky events: set wins over write-one clear
      irq_stat_reg <= irq_stat_reg | ev;
      if (do_write) begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped(aw_reg) ? 2'b00 : 2'b10;
        if (aw_reg == `MLA_ADDR_CTRL) begin
          ctrl_reg <= {29'h0, wd_reg[2:0]};
        end else if (aw_reg == `MLA_ADDR_IRQ_STAT) begin
          irq_stat_reg <= (irq_stat_reg & ~wd_reg[3:0]) | ev;
        end else if (aw_reg == `MLA_ADDR_IRQ_MASK) begin
          irq_mask_reg <= wd_reg[3:0];
        end else if (aw_reg == `MLA_ADDR_TX_WORD) begin
          tx_word_reg <= wd_reg[W-1:0];
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? 2'b00 : 2'b10;
        if (S_AXI_ARADDR == `MLA_ADDR_CTRL) begin
          S_AXI_RDATA <= ctrl_reg;
        end else if (S_AXI_ARADDR == `MLA_ADDR_STATUS) begin
          S_AXI_RDATA <= status;
        end else if (S_AXI_ARADDR == `MLA_ADDR_IRQ_STAT) begin
          S_AXI_RDATA <= {28'h0, irq_stat_reg};
        end else if (S_AXI_ARADDR == `MLA_ADDR_IRQ_MASK) begin
          S_AXI_RDATA <= {28'h0, irq_mask_reg};
        end else if (S_AXI_ARADDR == `MLA_ADDR_RX_WORD) begin
          S_AXI_RDATA <= {22'h0, CODE_GROUP_WORD};
        end else if (S_AXI_ARADDR == `MLA_ADDR_TX_WORD) begin
          S_AXI_RDATA <= {22'h0, tx_word_reg};
        end else begin
          S_AXI_RDATA <= 32'h00000000;
        end
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
      // one cycle late: irq follows registered status
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule // mla_top

// ==== rtl/mla_defines.vh ====
// constants for the media link loss-of-signal and alignment block
`ifndef MLA_DEFINES_VH
`define MLA_DEFINES_VH
`define MLA_ADDR_CTRL 8'h00
`define MLA_ADDR_STATUS 8'h04
`define MLA_ADDR_IRQ_STAT 8'h08
`define MLA_ADDR_IRQ_MASK 8'h0C
`define MLA_ADDR_RX_WORD 8'h10
`define MLA_ADDR_TX_WORD 8'h14
`define MLA_CTRL_RESET 32'h00000000
`define MLA_CTRL_PM_LSB 0
`define MLA_CTRL_AEN_BIT 2
`define MLA_PM_MON 2'h1
`define MLA_ST_LOS_ANOM 0
`define MLA_ST_LOS_DEF 1
`define MLA_ST_MON 2
`define MLA_ST_CAUSE 3
`define MLA_ST_FAULT 4
`define MLA_ST_SSF 5
`define MLA_ST_FS 6
`define MLA_IRQ_FAULT_SET 0
`define MLA_IRQ_FAULT_CLR 1
`define MLA_IRQ_FRAME 2
`define MLA_IRQ_WORD 3
`define MLA_COMMA 7'h7C
`define MLA_WORD_W 10
`define MLA_CLK_HZ 20000000
`define MLA_SET_TIME_MS 2500
`define MLA_CLR_TIME_MS 10000
`define MLA_MS_CYCLES (`MLA_CLK_HZ / 1000)
`define MLA_SET_CYCLES (`MLA_SET_TIME_MS * `MLA_MS_CYCLES)
`define MLA_CLR_CYCLES (`MLA_CLR_TIME_MS * `MLA_MS_CYCLES)
`endif

// ==== rtl/mla_fault_timer.v ====
// persistence filter turning the loss cause into a fault
`timescale 1ns/1ps
module mla_fault_timer #(
  parameter [31:0] SET_CYCLES = 32'd50000000,
  parameter [31:0] CLR_CYCLES = 32'd200000000
) (
  input wire clk,
  input wire rst,
  input wire cause,
  output reg fault_reg
);
  reg [31:0] cnt_reg;
  reg cause_d_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h00000000;
      cause_d_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      cause_d_reg <= cause;
      if (cause != cause_d_reg || cause == fault_reg) begin
        cnt_reg <= 32'h00000000;
      end else begin
        if (cause && cnt_reg >= SET_CYCLES - 32'd1) begin
          fault_reg <= 1'b1;
          cnt_reg <= 32'h00000000;
        end else if (!cause && cnt_reg >= CLR_CYCLES - 32'd1) begin
          fault_reg <= 1'b0;
          cnt_reg <= 32'h00000000;
        end else begin
          cnt_reg <= cnt_reg + 32'd1;
        end
      end
    end
  end
endmodule // mla_fault_timer

// ==== tb/mla_top_sva.sv ====
// assertion checker for the media link block ports
`timescale 1ns/1ps
module mla_top_sva #(
  parameter [31:0] SET_CYCLES = 32'd20,
  parameter [31:0] CLR_CYCLES = 32'd80
) (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // watched pins
  input wire LEVEL_BELOW_THRESH,
  input wire ALIGN_ENABLE_IN,
  input wire TRAIL_FAIL_IN,
  input wire TX_BIT,
  input wire TX_BIT_CLK,
  input wire FRAME_START_OUT,
  input wire SERVER_FAIL_OUT,
  input wire TRAIL_FAIL_TO_ADAPTER,
  input wire MGMT_SIGNAL_LOSS_CAUSE,
  input wire SIGNAL_LOSS_FAULT
);
  reg [31:0] run_reg;
  reg cause_reg;
  // cycles since the cause last changed
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      run_reg <= 32'h0;
      cause_reg <= 1'b0;
    end else begin
      cause_reg <= MGMT_SIGNAL_LOSS_CAUSE;
      if (cause_reg != MGMT_SIGNAL_LOSS_CAUSE) run_reg <= 32'h1;
      else run_reg <= run_reg + 32'h1;
    end
  end
  default clocking dc @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence enable_off;
    !ALIGN_ENABLE_IN [*8];
  endsequence
  sequence fault_up;
    $rose(SIGNAL_LOSS_FAULT);
  endsequence
  a_defect_lag: assert property (
    TRAIL_FAIL_TO_ADAPTER == $past(LEVEL_BELOW_THRESH, 3))
    else $error("defect not following level");
  a_server_follow: assert property (
    SERVER_FAIL_OUT == $past(TRAIL_FAIL_IN, 3))
    else $error("server fail not following input");
  a_cause_gate: assert property (
    MGMT_SIGNAL_LOSS_CAUSE |->
    TRAIL_FAIL_TO_ADAPTER || $past(TRAIL_FAIL_TO_ADAPTER))
    else $error("cause without defect");
  a_fault_set: assert property (
    fault_up |-> run_reg >= SET_CYCLES - 1 && run_reg <= SET_CYCLES + 2)
    else $error("fault set after wrong persistence");
  a_fault_clear: assert property (
    $fell(SIGNAL_LOSS_FAULT) |->
    run_reg >= CLR_CYCLES - 1 && run_reg <= CLR_CYCLES + 2)
    else $error("fault cleared after wrong persistence");
  a_fault_steady: assert property (
    $changed(SIGNAL_LOSS_FAULT) |->
    $past(MGMT_SIGNAL_LOSS_CAUSE) != $past(SIGNAL_LOSS_FAULT))
    else $error("fault moved while cause agreed");
  a_frame_gate: assert property (enable_off |=> !FRAME_START_OUT)
    else $error("frame start while alignment off");
  a_frame_pulse: assert property (FRAME_START_OUT |=> !FRAME_START_OUT)
    else $error("frame start longer than a cycle");
  a_tx_launch: assert property ($changed(TX_BIT) |-> $fell(TX_BIT_CLK))
    else $error("tx bit moved off its clock edge");
  a_tx_clock: assert property (TX_BIT_CLK |=> !TX_BIT_CLK)
    else $error("tx bit clock stalled");
endmodule // mla_top_sva
bind mla_top mla_top_sva #(.SET_CYCLES(SET_CYCLES), .CLR_CYCLES(CLR_CYCLES))
  i_mla_top_sva (.REF_CLK(REF_CLK), .RST(RST),
  .LEVEL_BELOW_THRESH(LEVEL_BELOW_THRESH), .ALIGN_ENABLE_IN(ALIGN_ENABLE_IN),
  .TRAIL_FAIL_IN(TRAIL_FAIL_IN), .TX_BIT(TX_BIT), .TX_BIT_CLK(TX_BIT_CLK),
  .FRAME_START_OUT(FRAME_START_OUT), .SERVER_FAIL_OUT(SERVER_FAIL_OUT),
  .TRAIL_FAIL_TO_ADAPTER(TRAIL_FAIL_TO_ADAPTER),
  .MGMT_SIGNAL_LOSS_CAUSE(MGMT_SIGNAL_LOSS_CAUSE),
  .SIGNAL_LOSS_FAULT(SIGNAL_LOSS_FAULT));

// ==== tb/mla_link_model.sv ====
// optical transceiver model driving the serial receive pins
`timescale 1ns/1ps
module mla_link_model (
  // serial receive pins
  output logic RX_BIT_CLK,
  output logic RX_BIT
);
  logic idle = 1'b1;
  initial begin
    RX_BIT_CLK = 1'b0;
    RX_BIT = 1'b0;
  end
  // released line keeps moving so a stale bit never looks valid
  always #37 if (idle) RX_BIT = ~RX_BIT;
  // top n bits, msb first, 400 ns bit period, clock still between calls
  task automatic send(input logic [9:0] w, input int n);
    idle = 1'b0;
    for (int k = 9; k > 9 - n; k--) begin
      RX_BIT = w[k];
      #100 RX_BIT_CLK = 1'b1;
      #200 RX_BIT_CLK = 1'b0;
      #100;
    end
    idle = 1'b1;
  endtask
endmodule // mla_link_model

// ==== tb/media_link_los_and_alignment_test.sv ====
// self-checking bench for the media link block
`timescale 1ns/1ps
`include "mla_defines.vh"
module media_link_los_and_alignment_test;
  localparam [31:0] SET_N = 32'd20;
  localparam [31:0] CLR_N = 32'd80;
  reg clk = 1'b0, rst = 1'b1, lvl = 1'b0, aen = 1'b0, tfi = 1'b0;
  reg awv = 1'b0, wv = 1'b0, arv = 1'b0, bry = 1'b1, rry = 1'b1;
  reg [3:0] ws = 4'hF;
  reg [9:0] txw = 10'h0;
  reg [7:0] awa = 8'h0, ara = 8'h0;
  reg [31:0] wd = 32'h0, rd, seed = 32'h2CBA;
  reg [1:0] rs;
  reg [9:0] exp_q[$];
  wire rxc, rxb, awr, wr, bv, arr, rv, tfa, ssf, fs, cause, fault, irq;
  wire txb, txc;
  reg [9:0] tx_sh = 10'h0;
  reg txc_d = 1'b0, sh_new = 1'b0;
  integer tx_hits = 0;
  wire [1:0] br, rr;
  wire [31:0] rdt;
  wire [9:0] cgw;
  integer fail_count = 0, n_compared = 0, fsn = 0, cyc_n = 0, i;
  mla_top #(.SET_CYCLES(SET_N), .CLR_CYCLES(CLR_N)) i_mla_top (
    .REF_CLK(clk), .RST(rst), .LEVEL_BELOW_THRESH(lvl), .RX_BIT_CLK(rxc),
    .RX_BIT(rxb), .TX_BIT(txb), .TX_BIT_CLK(txc), .ALIGN_ENABLE_IN(aen),
    .TRAIL_FAIL_IN(tfi), .CODE_GROUP_WORD(cgw), .CODE_GROUP_CLOCK(),
    .FRAME_START_OUT(fs), .SERVER_FAIL_OUT(ssf), .TRAIL_FAIL_TO_ADAPTER(tfa),
    .TX_CODE_GROUP(txw), .TX_CODE_GROUP_CLOCK(),
    .MGMT_SIGNAL_LOSS_CAUSE(cause), .SIGNAL_LOSS_FAULT(fault), .IRQ(irq),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdt), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry));
  mla_link_model i_mla_link_model (.RX_BIT_CLK(rxc), .RX_BIT(rxb));
  initial forever #25 clk = ~clk;
  function [31:0] xs(input [31:0] v);
    reg [31:0] x;
    begin
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task check(input [31:0] s, e, input string w);
    n_compared = n_compared + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("unexpected %0s expected %h seen %h", w, e, s);
    end
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wait_n(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // sampled at the falling edge, acted on at the next rising edge
  task wr_reg(input [7:0] a, input [31:0] d, input [1:0] er);
    reg aw, w, b;
    begin
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      b = 1'b0;
      while (!b) begin
        @(negedge clk);
        aw = awv && awr;
        w = wv && wr;
        b = bv;
        if (b) check(br, er, "bresp");
        @(posedge clk);
        if (aw) awv <= 1'b0;
        if (w) wv <= 1'b0;
      end
    end
  endtask
  task rd_reg(input [7:0] a);
    reg ar, r;
    begin
      ara <= a;
      arv <= 1'b1;
      r = 1'b0;
      while (!r) begin
        @(negedge clk);
        ar = arv && arr;
        r = rv;
        rd = rdt;
        rs = rr;
        @(posedge clk);
        if (ar) arv <= 1'b0;
      end
    end
  endtask
  always @(cgw) if (exp_q.size() > 0) check(cgw, exp_q.pop_front(), "word");
  always @(posedge clk) if (fs === 1'b1) fsn <= fsn + 1;
  // tx bits taken on tx clock rise; count each fresh comma window
  always @(posedge clk) begin
    txc_d <= txc;
    sh_new <= txc && !txc_d;
    if (txc && !txc_d) tx_sh <= {tx_sh[8:0], txb};
    if (sh_new && tx_sh == 10'h3E5) tx_hits <= tx_hits + 1;
  end
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fail_count = fail_count + 1;
      finish_test;
    end
  end
  initial begin
    wait_n(16);
    rst <= 1'b0;
    wait_n(1);
    wr_reg(`MLA_ADDR_CTRL, 32'h1, 2'b00);
    wr_reg(`MLA_ADDR_IRQ_MASK, 32'h1, 2'b00);
    wr_reg(8'h40, 32'h1, 2'b10);
    lvl <= 1'b1;
    wait_n(5);
    check(tfa, 1, "defect");
    check(cause, 1, "cause");
    wait_n(10);
    // short dropout must restart the persistence count
    lvl <= 1'b0;
    wait_n(6);
    lvl <= 1'b1;
    wait_n(16);
    check(fault, 0, "early fault");
    wait_n(12);
    check(fault, 1, "fault");
    check(irq, 1, "irq");
    rd_reg(`MLA_ADDR_IRQ_STAT);
    check(rd[0], 1, "set event");
    wr_reg(`MLA_ADDR_IRQ_STAT, 32'h1, 2'b00);
    wait_n(3);
    check(irq, 0, "irq clear");
    wr_reg(`MLA_ADDR_CTRL, 32'h0, 2'b00);
    wait_n(3);
    rd_reg(`MLA_ADDR_STATUS);
    check(rd[6:0], 7'h13, "status");
    wait_n(50);
    check(fault, 1, "fault hold");
    wait_n(40);
    check(fault, 0, "fault clear");
    check(irq, 0, "masked irq");
    lvl <= 1'b0;
    tfi <= 1'b1;
    wait_n(4);
    check(ssf, 1, "server fail");
    tfi <= 1'b0;
    rd_reg(8'h40);
    check(rs, 2'b10, "rresp");
    check(rd, 0, "rdata");
    $display("test loss done");
    // three stray bits, then a comma that must move the boundary
    aen <= 1'b1;
    wait_n(4);
    i_mla_link_model.send(10'h280, 3);
    exp_q.push_back(10'h3E5);
    i_mla_link_model.send(10'h3E5, 10);
    wait_n(1);
    aen <= 1'b0;
    wait_n(4);
    check(fsn, 1, "frame starts");
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      wait_n(1);
      txw <= seed[19:10];
      exp_q.push_back(seed[9:0]);
      i_mla_link_model.send(seed[9:0], 10);
    end
    // comma off the boundary while disabled: no pulse, no realign
    exp_q.push_back(10'h3F9);
    exp_q.push_back(10'h100);
    i_mla_link_model.send(10'h300, 2);
    i_mla_link_model.send(10'h3E5, 10);
    i_mla_link_model.send(10'h000, 8);
    wait_n(20);
    check(fsn, 1, "no frame start");
    check(exp_q.size(), 0, "words left");
    rd_reg(`MLA_ADDR_RX_WORD);
    check(rd[9:0], 10'h100, "rx word reg");
    $display("test link done");
    // register source: a looped comma word must show msb first
    wr_reg(`MLA_ADDR_TX_WORD, 32'h3E5, 2'b00);
    wr_reg(`MLA_ADDR_CTRL, 32'h4, 2'b00);
    i = tx_hits;
    wait_n(100);
    check(tx_hits - i >= 3, 1, "tx comma");
    rd_reg(`MLA_ADDR_TX_WORD);
    check(rd[9:0], 10'h3E5, "tx word reg");
    $display("test transmit done");
    finish_test;
  end
endmodule // media_link_los_and_alignment_test
